// file: design/boot_seq_pkg.sv
package boot_seq_pkg;
    // timing
    localparam int CLK_PERIOD_NS     = 50;
    localparam int DEFAULT_INIT_MS   = 100;
    localparam int NS_PER_MS         = 1000000;
    localparam int DEFAULT_INIT_CYC  = DEFAULT_INIT_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int CLEAR_WORDS       = 1024;

    // two-wire addresses, 7-bit form, select pin in bit 0
    localparam logic [5:0] SLAVE_ADDR_BASE  = 6'h1a;
    localparam logic [5:0] MASTER_ADDR_BASE = 6'h28;
    localparam logic [7:0] STATUS_SUBADDR   = 8'h02;

    // image header codes
    localparam logic [7:0] HDR_END  = 8'h00;
    localparam logic [7:0] HDR_PROG = 8'h01;
    localparam logic [7:0] HDR_COEF = 8'h02;
    localparam logic [7:0] HDR_DATA = 8'h03;

    // memory selects
    localparam logic [1:0] MEM_PROG = 2'h0;
    localparam logic [1:0] MEM_COEF = 2'h1;
    localparam logic [1:0] MEM_DATA = 2'h2;
    localparam logic [1:0] MEM_ALL  = 2'h3;

    // status register bits
    localparam int ST_BIT_DONE    = 0;
    localparam int ST_BIT_OK      = 1;
    localparam int ST_BIT_NOMEM   = 2;
    localparam int ST_BIT_RDERR   = 3;
    localparam int ST_BIT_STRAP   = 4;
    localparam int ST_BIT_BADIMG  = 5;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

    typedef enum logic [3:0] {
        S_HOUSE, S_DEFAULTS, S_PROBE, S_HDR_TYPE, S_HDR_LEN, S_DATA,
        S_HANDOFF_OK, S_HANDOFF_FAIL, S_DEFAULT_INIT, S_RUN_FW, S_RUN_DEFAULT
    } seq_state_t;

    typedef struct packed {
        logic       start;
        logic       rdReq;
        logic [6:0] devAddr;
    } mst_req_t;

    typedef struct packed {
        logic       done;
        logic       nack;
        logic       err;
        logic       rdValid;
        logic [7:0] rdByte;
    } mst_rsp_t;

    typedef struct packed {
        logic        we;
        logic [1:0]  sel;
        logic [15:0] addr;
        logic [7:0]  data;
    } mem_wr_t;
endpackage

// file: design/reset_boot_sequencer.sv
`timescale 1ns/1ns
// Functional notes
// - reset high-active pin restores everything asynchronously; held while asserted
// - in reset, bus activity ignored and clock/data lines left undriven
// - audio core idles from reset while controller initializes
// - reset release starts memory clear and default register load first
// - after housekeeping: master port on, slave port off, boot begins
// - probe eeprom at address prefix 1010x through master port
// - load program, coefficient, data memories; end header completes download
// - success: master off, slave on, controller counter reset, firmware runs
// - no eeprom or read error: master off, slave on, slave defaults loaded
// - master and slave ports never active together
// - failed boot, strap high: serial outputs inactive, strap driven low later
// - read error recorded in status register at subaddress 0x02
// - failed boot, strap low: status, slave on, strap low, audio passthrough
// - default initialization ends about 100 ms after reset
// - regulator shutdown high loses all state until full restart
// - failed boot and standby pin low: stop clocks, analog off, volume ramp
// - after successful boot firmware decides standby pin behaviour
// - analog reference off only when all converters already off
// - address select pin picks one of two slave and master addresses
// - strap is input at power-up; firmware owns it after good boot
// - aux pins three and four may serve as serial inputs one and two
module reset_boot_sequencer #(
    parameter int CLR_WORDS  = boot_seq_pkg::CLEAR_WORDS,
    parameter int INIT_CYC   = boot_seq_pkg::DEFAULT_INIT_CYC
) (
    // clock, reset
    input  wire logic                   ref_clk,
    input  wire logic                   reset,
    input  wire logic                   ce,
    input  wire logic                   regulatorShutdownPin,
    // two-wire master engine
    output boot_seq_pkg::mst_req_t      mstReq,
    input  wire boot_seq_pkg::mst_rsp_t mstRsp,
    input  wire logic                   engSclOe,
    input  wire logic                   engSdaOe,
    output logic                        sclOe,
    output logic                        sdaOe,
    output logic                        masterEnable,
    output logic                        slaveEnable,
    input  wire logic                   busAddressSelect,
    output logic [6:0]                  slaveAddr,
    output logic [6:0]                  masterAddr,
    // slave register read
    input  wire logic                   slvRd,
    input  wire logic [7:0]             slvSubAddr,
    output logic [31:0]                 slvRdData,
    output logic                        slvRdValid,
    // memory writes
    output boot_seq_pkg::mem_wr_t       memWr,
    // controller and core
    output logic                        regDefaultsLoad,
    output logic                        slaveDefaultsLoad,
    output logic                        mcuPcReset,
    output logic                        audioCoreIdle,
    output logic                        regulatorsOff,
    // strap and aux pins
    input  wire logic                   bootStrapIoIn,
    output logic                        bootStrapIoOut,
    output logic                        bootStrapIoOe,
    input  wire logic                   fwStrapOut,
    input  wire logic                   fwStrapOe,
    input  wire logic [1:0]             auxSerialSel,
    input  wire logic                   auxIoThreeIn,
    input  wire logic                   auxIoFourIn,
    // serial audio
    input  wire logic [1:0]             coreSerialOut,
    output logic [1:0]                  serialAudioIn,
    output logic                        serialAudioOutOne,
    output logic                        serialAudioOutTwo,
    // power
    input  wire logic                   standbyRequestPin,
    input  wire logic                   fwStandby,
    input  wire logic [3:0]             adcDown,
    input  wire logic [3:0]             dacDown,
    input  wire logic                   refDownReq,
    output logic                        clocksStop,
    output logic                        analogPowerDown,
    output logic                        volumeRampDown,
    output logic                        refPowerDown
);
    import boot_seq_pkg::*;
    seq_state_t  state_r, state_nxt;
    logic [31:0] status_r;
    logic [15:0] clrCnt_r;
    logic [15:0] addr_r;
    logic [7:0]  remain_r;
    logic [1:0]  memSel_r;
    logic        anyBlock_r;
    logic        strapHigh_r;
    logic [31:0] initCnt_r;
    logic        rstAll;
    logic        failedRun;
    // shutdown drops every flop just like the reset pin
    assign rstAll = reset | regulatorShutdownPin;
    assign regulatorsOff = regulatorShutdownPin;
    function automatic logic isHeader(input logic [7:0] b);
        isHeader = (b == HDR_PROG) || (b == HDR_COEF) || (b == HDR_DATA);
    endfunction
    function automatic logic [1:0] hdrSel(input logic [7:0] b);
        hdrSel = (b == HDR_PROG) ? MEM_PROG : (b == HDR_COEF) ? MEM_COEF : MEM_DATA;
    endfunction
    assign slaveAddr  = {SLAVE_ADDR_BASE, busAddressSelect};
    assign masterAddr = {MASTER_ADDR_BASE, busAddressSelect};
    // port enables decoded straight from state; handoff states keep both off
    assign masterEnable = (state_r == S_PROBE) || (state_r == S_HDR_TYPE)
                       || (state_r == S_HDR_LEN) || (state_r == S_DATA);
    assign slaveEnable  = (state_r == S_RUN_FW) || (state_r == S_RUN_DEFAULT);
    assign sclOe = (masterEnable | slaveEnable) & engSclOe;
    assign sdaOe = (masterEnable | slaveEnable) & engSdaOe;
    assign audioCoreIdle = !slaveEnable;
    assign failedRun = (state_r == S_DEFAULT_INIT) || (state_r == S_RUN_DEFAULT);
    always_comb begin
        mstReq.start   = (state_r == S_PROBE);
        mstReq.devAddr = masterAddr;
        mstReq.rdReq   = (state_r == S_HDR_TYPE) || (state_r == S_HDR_LEN)
                      || (state_r == S_DATA);
    end
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            S_HOUSE: begin
                if (clrCnt_r == 16'(CLR_WORDS - 1)) begin
                    state_nxt = S_DEFAULTS;
                end
            end
            S_DEFAULTS: state_nxt = S_PROBE;
            S_PROBE: begin
                if (mstRsp.done && (mstRsp.nack || mstRsp.err)) begin
                    state_nxt = S_HANDOFF_FAIL;
                end else if (mstRsp.done) begin
                    state_nxt = S_HDR_TYPE;
                end
            end
            S_HDR_TYPE: begin
                if (mstRsp.err) begin
                    state_nxt = S_HANDOFF_FAIL;
                end else if (mstRsp.rdValid && mstRsp.rdByte == HDR_END) begin
                    state_nxt = anyBlock_r ? S_HANDOFF_OK : S_HANDOFF_FAIL;
                end else if (mstRsp.rdValid && isHeader(mstRsp.rdByte)) begin
                    state_nxt = S_HDR_LEN;
                end else if (mstRsp.rdValid) begin
                    state_nxt = S_HANDOFF_FAIL;
                end
            end
            S_HDR_LEN: begin
                if (mstRsp.err) begin
                    state_nxt = S_HANDOFF_FAIL;
                end else if (mstRsp.rdValid) begin
                    state_nxt = (mstRsp.rdByte == 8'h00) ? S_HDR_TYPE : S_DATA;
                end
            end
            S_DATA: begin
                if (mstRsp.err) begin
                    state_nxt = S_HANDOFF_FAIL;
                end else if (mstRsp.rdValid && remain_r == 8'h01) begin
                    state_nxt = S_HDR_TYPE;
                end
            end
            S_HANDOFF_OK:   state_nxt = S_RUN_FW;
            S_HANDOFF_FAIL: state_nxt = S_DEFAULT_INIT;
            S_DEFAULT_INIT: begin
                if (initCnt_r >= 32'(INIT_CYC)) begin
                    state_nxt = S_RUN_DEFAULT;
                end
            end
            default: state_nxt = state_r;
        endcase
    end
    always_ff @(posedge ref_clk or posedge rstAll) begin
        if (rstAll) begin
            state_r <= S_HOUSE;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end
    // time since reset release, saturating
    always_ff @(posedge ref_clk or posedge rstAll) begin
        if (rstAll) begin
            initCnt_r <= 32'h0000_0000;
        end else if (ce && initCnt_r < 32'(INIT_CYC)) begin
            initCnt_r <= initCnt_r + 32'h0000_0001;
        end
    end
    // housekeeping clear of all memories, then the image loader
    always_ff @(posedge ref_clk or posedge rstAll) begin
        if (rstAll) begin
            clrCnt_r   <= 16'h0000;
            addr_r     <= 16'h0000;
            remain_r   <= 8'h00;
            memSel_r   <= MEM_PROG;
            anyBlock_r <= 1'b0;
            memWr      <= '0;
        end else if (ce) begin
            memWr.we <= 1'b0;
            if (state_r == S_HOUSE) begin
                memWr    <= '{we: 1'b1, sel: MEM_ALL, addr: clrCnt_r, data: 8'h00};
                clrCnt_r <= clrCnt_r + 16'h0001;
            end else if (state_r == S_HDR_TYPE && mstRsp.rdValid
                         && isHeader(mstRsp.rdByte)) begin
                memSel_r <= hdrSel(mstRsp.rdByte);
                addr_r   <= 16'h0000;
            end else if (state_r == S_HDR_LEN && mstRsp.rdValid) begin
                remain_r <= mstRsp.rdByte;
            end else if (state_r == S_DATA && mstRsp.rdValid) begin
                memWr      <= '{we: 1'b1, sel: memSel_r, addr: addr_r,
                                data: mstRsp.rdByte};
                addr_r     <= addr_r + 16'h0001;
                remain_r   <= remain_r - 8'h01;
                anyBlock_r <= 1'b1;
            end
        end
    end
    // strap caught after release, never inside the reset term
    always_ff @(posedge ref_clk or posedge rstAll) begin
        if (rstAll) begin
            strapHigh_r <= 1'b0;
        end else if (ce && state_r == S_DEFAULTS) begin
            strapHigh_r <= bootStrapIoIn;
        end
    end
    // status: error bits latched as they happen, outcome bits at good handoff or at end of default init
    always_ff @(posedge ref_clk or posedge rstAll) begin
        if (rstAll) begin
            status_r <= STATUS_RESET;
        end else if (ce) begin
            if (state_r == S_PROBE && mstRsp.done && mstRsp.nack) begin
                status_r[ST_BIT_NOMEM] <= 1'b1;
            end
            if (masterEnable && mstRsp.err) begin
                status_r[ST_BIT_RDERR] <= 1'b1;
            end
            if (state_r == S_HDR_TYPE && mstRsp.rdValid && !mstRsp.err
                && !(isHeader(mstRsp.rdByte) || (mstRsp.rdByte == HDR_END && anyBlock_r))) begin
                status_r[ST_BIT_BADIMG] <= 1'b1;
            end
            if (state_r == S_HANDOFF_OK) begin
                status_r[ST_BIT_OK]   <= 1'b1;
                status_r[ST_BIT_DONE] <= 1'b1;
            end
            if (state_r == S_DEFAULT_INIT && state_nxt == S_RUN_DEFAULT) begin
                status_r[ST_BIT_DONE]  <= 1'b1;
                status_r[ST_BIT_STRAP] <= strapHigh_r;
            end
        end
    end
    // slave reads only answer once the slave port is up
    always_ff @(posedge ref_clk or posedge rstAll) begin
        if (rstAll) begin
            slvRdData  <= 32'h0000_0000;
            slvRdValid <= 1'b0;
        end else if (ce) begin
            slvRdValid <= slvRd && slaveEnable;
            if (slvRd && slaveEnable) begin
                slvRdData <= (slvSubAddr == STATUS_SUBADDR) ? status_r : 32'h0000_0000;
            end
        end
    end
    // one-cycle strobes to the controller
    always_ff @(posedge ref_clk or posedge rstAll) begin
        if (rstAll) begin
            regDefaultsLoad   <= 1'b0;
            slaveDefaultsLoad <= 1'b0;
            mcuPcReset        <= 1'b0;
        end else if (ce) begin
            regDefaultsLoad   <= (state_r == S_DEFAULTS);
            slaveDefaultsLoad <= (state_r == S_HANDOFF_FAIL);
            mcuPcReset        <= (state_r == S_HANDOFF_OK);
        end
    end
    // strap pin: input until a run state, then low or firmware-owned
    always_comb begin
        bootStrapIoOe  = 1'b0;
        bootStrapIoOut = 1'b0;
        if (state_r == S_RUN_DEFAULT) begin
            bootStrapIoOe = 1'b1;
        end else if (state_r == S_RUN_FW) begin
            bootStrapIoOe  = fwStrapOe;
            bootStrapIoOut = fwStrapOut;
        end
    end
    // aux pins feed the serial inputs when selected
    assign serialAudioIn[0] = auxSerialSel[0] & auxIoThreeIn;
    assign serialAudioIn[1] = auxSerialSel[1] & auxIoFourIn;
    // audio outputs and power controls, all flopped
    always_ff @(posedge ref_clk or posedge rstAll) begin
        if (rstAll) begin
            serialAudioOutOne <= 1'b0;
            serialAudioOutTwo <= 1'b0;
            clocksStop        <= 1'b0;
            analogPowerDown   <= 1'b0;
            volumeRampDown    <= 1'b0;
            refPowerDown      <= 1'b0;
        end else if (ce) begin
            if (state_r == S_RUN_FW) begin
                serialAudioOutOne <= coreSerialOut[0];
                serialAudioOutTwo <= coreSerialOut[1];
            end else if (state_r == S_RUN_DEFAULT && !strapHigh_r) begin
                serialAudioOutOne <= serialAudioIn[0];
                serialAudioOutTwo <= serialAudioIn[1];
            end else begin
                serialAudioOutOne <= 1'b0;
                serialAudioOutTwo <= 1'b0;
            end
            if (state_r == S_RUN_FW) begin
                clocksStop      <= fwStandby;
                analogPowerDown <= fwStandby;
                volumeRampDown  <= fwStandby;
            end else begin
                clocksStop      <= failedRun && !standbyRequestPin;
                analogPowerDown <= failedRun && !standbyRequestPin;
                volumeRampDown  <= failedRun && !standbyRequestPin;
            end
            refPowerDown <= refDownReq && (&adcDown) && (&dacDown);
        end
    end
    property p_ports_exclusive;
        @(posedge ref_clk) disable iff (rstAll) !(masterEnable && slaveEnable);
    endproperty
    a_ports_exclusive: assert property (p_ports_exclusive) else $error("ports both on");
    property p_master_after_house;
        @(posedge ref_clk) disable iff (rstAll)
            (ce && state_r == S_DEFAULTS) |=> masterEnable && !slaveEnable;
    endproperty
    a_master_after_house: assert property (p_master_after_house) else $error("no master");
    property p_nack_fails;
        @(posedge ref_clk) disable iff (rstAll)
            (ce && state_r == S_PROBE && mstRsp.done && mstRsp.nack)
            |=> status_r[ST_BIT_NOMEM] && !masterEnable && !slaveEnable;
    endproperty
    a_nack_fails: assert property (p_nack_fails) else $error("nack not failed");
    property p_err_recorded;
        @(posedge ref_clk) disable iff (rstAll)
            (ce && masterEnable && mstRsp.err) |=> status_r[ST_BIT_RDERR];
    endproperty
    a_err_recorded: assert property (p_err_recorded) else $error("error not logged");
    property p_ref_guard;
        @(posedge ref_clk) disable iff (rstAll)
            $rose(refPowerDown) |-> $past(&adcDown) && $past(&dacDown);
    endproperty
    a_ref_guard: assert property (p_ref_guard) else $error("ref down early");
    property p_passthrough;
        @(posedge ref_clk) disable iff (rstAll)
            (ce && state_r == S_RUN_DEFAULT && !strapHigh_r)
            |=> serialAudioOutOne == $past(serialAudioIn[0]);
    endproperty
    a_passthrough: assert property (p_passthrough) else $error("no passthrough");
    property p_strap_low;
        @(posedge ref_clk) disable iff (rstAll)
            (state_r == S_RUN_DEFAULT) |-> bootStrapIoOe && !bootStrapIoOut
                                           && status_r[ST_BIT_DONE];
    endproperty
    a_strap_low: assert property (p_strap_low) else $error("strap not low");
    property p_quiet_bus;
        @(posedge ref_clk) disable iff (rstAll)
            (state_r == S_HOUSE) |-> !sclOe && !sdaOe && !slvRdValid;
    endproperty
    a_quiet_bus: assert property (p_quiet_bus) else $error("bus driven early");
    property p_standby;
        @(posedge ref_clk) disable iff (rstAll)
            (ce && state_r == S_RUN_DEFAULT && !standbyRequestPin) |=> clocksStop;
    endproperty
    a_standby: assert property (p_standby) else $error("standby missed");
    c_boot_ok: cover property (@(posedge ref_clk) disable iff (rstAll) state_r == S_HANDOFF_OK);
    c_no_mem: cover property (@(posedge ref_clk) disable iff (rstAll)
        state_r == S_PROBE && mstRsp.done && mstRsp.nack);
    c_default_run: cover property (@(posedge ref_clk) disable iff (rstAll)
        state_r == S_RUN_DEFAULT);
endmodule

// file: tb/eeprom_model.sv
`timescale 1ns/1ns
module eeprom_model (
    // clock and presence
    input  wire logic                   ref_clk,
    input  wire logic                   present,
    input  wire logic                   fail,
    // engine side
    input  wire boot_seq_pkg::mst_req_t req,
    output boot_seq_pkg::mst_rsp_t      rsp
);
    // coef block of two bytes, then end header
    logic [7:0] img [5] = '{8'h02, 8'h02, 8'h5a, 8'hc3, 8'h00};
    int         idx = 0;
    int         cnt = 0;
    initial rsp = '0;
    always @(posedge ref_clk) begin
        rsp.done    <= 1'b0;
        rsp.err     <= 1'b0;
        rsp.rdValid <= 1'b0;
        // bus released: stale byte inverted
        rsp.rdByte  <= ~rsp.rdByte;
        cnt         <= (req.start | req.rdReq) ? cnt + 1 : 0;
        if (req.start) begin
            idx <= 0;
        end
        if (cnt == 2 && req.start) begin
            rsp.done <= 1'b1;
            rsp.nack <= !(present && req.devAddr[6:3] == 4'b1010);
            cnt      <= 0;
        end else if (cnt == 2 && req.rdReq) begin
            // a failing part answers a read with an error pulse instead of data
            rsp.rdValid <= !fail;
            rsp.err     <= fail;
            rsp.rdByte  <= img[idx];
            idx         <= idx + 1;
            cnt         <= 0;
        end
    end
endmodule

// file: tb/reset_boot_sequencer_tb.sv
`timescale 1ns/1ns
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin bad_count++; \
    $display("ERROR %s exp %0h got %0h", n, e, s); end end
module reset_boot_sequencer_tb;
    localparam int INIT = 200;
    logic        ref_clk = 0;
    logic        reset = 1;
    logic        shutPin = 0;
    logic        present = 0;
    logic        strap = 0;
    logic        standby_request_pin = 1;
    logic        fail = 0;
    logic        prevRst = 1;
    logic        slvRd = 0;
    logic [7:0]  subAddr = 8'h00;
    logic [31:0] seed = 32'h4103;
    logic [31:0] prevSeed = 32'h0000_0000;
    logic [7:0]  imgData [2] = '{8'h5a, 8'hc3};
    int          bad_count = 0;
    int          checked = 0;
    int          cyc = 0;
    int          c [4];
    logic [21:0] snap;
    boot_seq_pkg::mem_wr_t  got [$];
    boot_seq_pkg::mst_req_t mstReq;
    boot_seq_pkg::mst_rsp_t mstRsp;
    boot_seq_pkg::mem_wr_t  memWr;
    logic sclOe, sdaOe, masterEnable, slaveEnable, slvRdValid, regDefaultsLoad, out1, out2;
    logic slaveDefaultsLoad, mcuPcReset, audioCoreIdle, regulatorsOff, bootStrapIoOut;
    logic bootStrapIoOe, clocksStop, analogPowerDown, volumeRampDown, refPwr;
    logic [6:0]  slaveAddr, masterAddr;
    logic [31:0] slvRdData;
    wire         strapWire = bootStrapIoOe ? bootStrapIoOut : strap;

    reset_boot_sequencer #(.CLR_WORDS(8), .INIT_CYC(INIT)) uut (
        .ref_clk, .reset, .ce(1'b1), .regulatorShutdownPin(shutPin), .mstReq, .mstRsp,
        .engSclOe(seed[0]), .engSdaOe(seed[1]), .sclOe, .sdaOe, .masterEnable, .slaveEnable,
        .busAddressSelect(seed[2]), .slaveAddr, .masterAddr, .slvRd, .slvSubAddr(subAddr),
        .slvRdData, .slvRdValid, .memWr, .regDefaultsLoad, .slaveDefaultsLoad, .mcuPcReset,
        .audioCoreIdle, .regulatorsOff, .bootStrapIoIn(strapWire), .bootStrapIoOut,
        .bootStrapIoOe, .fwStrapOut(seed[9]), .fwStrapOe(seed[10]), .auxSerialSel(seed[4:3]),
        .auxIoThreeIn(seed[5]), .auxIoFourIn(seed[6]), .coreSerialOut(seed[8:7]),
        .serialAudioIn(), .serialAudioOutOne(out1), .serialAudioOutTwo(out2),
        .standbyRequestPin(standby_request_pin), .fwStandby(seed[20]), .adcDown(seed[14:11]),
        .dacDown(seed[18:15]), .refDownReq(seed[19]), .clocksStop, .analogPowerDown,
        .volumeRampDown, .refPowerDown(refPwr)
    );
    eeprom_model mem (.ref_clk, .present, .fail, .req(mstReq), .rsp(mstRsp));

    function automatic logic [31:0] xs(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    // free-running from time zero so reset release sees a live clock
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        seed <= xs(seed);
        cyc  <= cyc + 1;
        // what the design sampled at this edge, for flopped outputs
        prevSeed <= seed;
        prevRst  <= reset | shutPin;
        if (cyc == 5000) begin
            bad_count++;
            summarize();
        end
    end
    always @(negedge ref_clk) begin
        if (memWr.we && memWr.sel == boot_seq_pkg::MEM_ALL) c[0]++;
        else if (memWr.we) got.push_back(memWr);
        c[1] += regDefaultsLoad;
        c[2] += mcuPcReset;
        c[3] += slaveDefaultsLoad;
        if (mstReq.start) snap = {masterEnable, slaveEnable, mstReq.devAddr[6:3], 8'(c[0]),
            8'(c[1])};
        `CHK("ports", 1'b0, masterEnable & slaveEnable)
        `CHK("addr", {boot_seq_pkg::SLAVE_ADDR_BASE, seed[2]}, slaveAddr)
        `CHK("maddr", {boot_seq_pkg::MASTER_ADDR_BASE, seed[2]}, masterAddr)
        if (!(reset | shutPin | prevRst))
            `CHK("ref down", prevSeed[19] & (&prevSeed[18:11]), refPwr)
    end

    task automatic boot(input logic p, input logic s, input logic f, output int n);
        @(posedge ref_clk);
        present <= p;
        fail    <= f;
        strap   <= s;
        standby_request_pin     <= 1'b1;
        reset   <= 1'b1;
        repeat (20) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK("in reset", 5'h01, {sclOe, sdaOe, masterEnable, slaveEnable, audioCoreIdle})
        c = '{default: 0};
        got.delete();
        @(posedge ref_clk);
        reset <= 1'b0;
        for (n = 0; n < 1000 && slaveEnable !== 1'b1; n++) @(negedge ref_clk);
        // one more edge so the handoff strobe is surely counted
        @(negedge ref_clk);
        `CHK("house", {6'b101010, 8'd8, 8'd1}, snap)
    endtask

    task automatic rd(input logic [7:0] a, output logic [32:0] r);
        @(posedge ref_clk);
        slvRd   <= 1'b1;
        subAddr <= a;
        @(posedge ref_clk);
        slvRd   <= 1'b0;
        @(negedge ref_clk);
        r = {slvRdValid, slvRdData};
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        automatic int         n;
        automatic logic [32:0] r;
        automatic logic [1:0]  e;
        boot(1'b1, 1'b0, 1'b0, n);
        `CHK("loads", 2, got.size())
        for (int i = 0; i < 2; i++) begin
            `CHK("load", {boot_seq_pkg::MEM_COEF, 16'(i), imgData[i]}, got[i][25:0])
        end
        `CHK("pc reset", 1, c[2])
        rd(8'h02, r);
        `CHK("status ok", {1'b1, 32'h3}, r)
        rd(8'h07, r);
        `CHK("unmapped", {1'b1, 32'h0}, r)
        @(posedge ref_clk);
        standby_request_pin <= 1'b0;
        repeat (2) @(negedge ref_clk);
        `CHK("fw standby", prevSeed[20], clocksStop)
        @(posedge ref_clk);
        shutPin <= 1'b1;
        @(negedge ref_clk);
        `CHK("regs off", 3'b100, {regulatorsOff, slaveEnable, masterEnable})
        @(posedge ref_clk);
        shutPin <= 1'b0;
        boot(1'b0, 1'b1, 1'b0, n);
        `CHK("init time", 1'b1, n > INIT - 3 && n < INIT + 8)
        `CHK("slave dflt", 1, c[3])
        rd(8'h02, r);
        `CHK("status hi", {1'b1, 32'h15}, r)
        `CHK("strap drv", 2'b10, {bootStrapIoOe, bootStrapIoOut})
        @(posedge ref_clk);
        standby_request_pin <= 1'b0;
        repeat (16) begin
            @(negedge ref_clk);
            `CHK("muted", 2'b00, {out2, out1})
        end
        `CHK("standby", 3'b111, {clocksStop, analogPowerDown, volumeRampDown})
        // memory answers the probe, then fails its first read
        boot(1'b1, 1'b0, 1'b1, n);
        `CHK("rd err dflt", 1, c[3])
        rd(8'h02, r);
        `CHK("status lo", {1'b1, 32'h9}, r)
        e = {seed[6] & seed[4], seed[5] & seed[3]};
        repeat (16) begin
            @(negedge ref_clk);
            `CHK("passthru", e, {out2, out1})
            e = {seed[6] & seed[4], seed[5] & seed[3]};
        end
        summarize();
    end
endmodule
